// *** timer16_irq_pkg.sv ***
package timer16_irq_pkg;

  // three timers: index 0 is timer 1, index 1 is timer 3, index 2 is timer 4
  localparam int NUM_TIMERS = 3;
  localparam int T4_INDEX   = 2;

  // data-space offsets of the registers
  localparam logic [7:0] TIMER1_FLAGS_ADDR   = 8'h36;
  localparam logic [7:0] TIMER3_FLAGS_ADDR   = 8'h38;
  localparam logic [7:0] TIMER4_FLAGS_ADDR   = 8'h39;
  localparam logic [7:0] TIMER4_ENABLES_ADDR = 8'h72;

  // i/o-space accesses are data offset minus this, limited to 0x00..0x3f
  localparam logic [7:0] IO_SPACE_OFFSET = 8'h20;
  localparam logic [1:0] IO_RANGE_HIGH   = 2'h0;

  // reset values and implemented bits
  localparam logic [7:0] FLAGS_RESET   = 8'h00;
  localparam logic [7:0] ENABLES_RESET = 8'h00;
  localparam logic [7:0] FLAG_MASK     = 8'h27;
  localparam logic [7:0] ENABLE_MASK   = 8'h27;
  localparam logic [7:0] READ_IDLE     = 8'h00;

  // flag and enable bit positions
  localparam int CAPTURE_BIT   = 5;
  localparam int COMPARE_B_BIT = 2;
  localparam int COMPARE_A_BIT = 1;
  localparam int OVERFLOW_BIT  = 0;

  // waveform modes that matter to the flags
  localparam logic [3:0] MODE_NORMAL         = 4'h0;
  localparam logic [3:0] MODE_CTC_COMPARE    = 4'h4;
  localparam logic [3:0] MODE_PFC_CAPTURE    = 4'h8;
  localparam logic [3:0] MODE_PC_CAPTURE     = 4'ha;
  localparam logic [3:0] MODE_CTC_CAPTURE    = 4'hc;
  localparam logic [3:0] MODE_FAST_CAPTURE   = 4'he;

  // per-timer status coming from the counter logic
  typedef struct packed {
    logic        tick;
    logic        capture_event;
    logic        counter_at_top;
    logic        overflow_event;
    logic        mode_overflow_event;
    logic        force_compare_a_strobe;
    logic        force_compare_b_strobe;
    logic [3:0]  waveform_mode_field;
    logic [15:0] counter_value;
    logic [15:0] compare_a_register;
    logic [15:0] compare_b_register;
  } timer_status_s;

  // per-timer vector execution acknowledges
  typedef struct packed {
    logic capture;
    logic compare_b;
    logic compare_a;
    logic overflow;
  } vector_ack_s;

  // one core register access
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       io_space;
    logic [7:0] addr;
    logic [7:0] wdata;
  } core_access_s;

endpackage

// *** timer16_irq_flag_logic.sv ***
`timescale 1ns/1ps
module timer16_irq_flag_logic
  import timer16_irq_pkg::*;
(
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               reset_n,
  // core register access
  input  wire core_access_s       core_access,
  output logic [7:0]              core_rdata,
  // global interrupt flag of the core
  input  wire logic               global_irq_enable,
  // timer status and vector acknowledges
  input  wire timer_status_s      timer_status [NUM_TIMERS],
  input  wire vector_ack_s        vector_ack   [NUM_TIMERS],
  // flag view and timer 4 requests
  output logic [7:0]              event_flags  [NUM_TIMERS],
  output logic                    t4_compare_a_irq,
  output logic                    t4_overflow_irq
);

  // every property below belongs to the one system clock and is off during reset
  default clocking flag_cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  // returns one-hot hit on the flag registers for a data-space address
  function automatic logic [NUM_TIMERS-1:0] flag_hit(input logic [7:0] a);
    flag_hit = {a == TIMER4_FLAGS_ADDR, a == TIMER3_FLAGS_ADDR, a == TIMER1_FLAGS_ADDR};
  endfunction

  // modes that take the capture register as top
  function automatic logic capture_is_top(input logic [3:0] m);
    capture_is_top = (m == MODE_PFC_CAPTURE) || (m == MODE_PC_CAPTURE) ||
                     (m == MODE_CTC_CAPTURE) || (m == MODE_FAST_CAPTURE);
  endfunction

  logic [7:0]            data_addr;
  logic                  addr_valid;
  logic [NUM_TIMERS-1:0] hit;
  logic                  enables_hit;

  // io offset map
  // i/o accesses above 0x3f cannot exist on the core, so they are dropped
  always_comb begin
    data_addr   = core_access.io_space ? core_access.addr + IO_SPACE_OFFSET : core_access.addr;
    addr_valid  = !core_access.io_space || (core_access.addr[7:6] == IO_RANGE_HIGH);
    hit         = addr_valid ? flag_hit(data_addr) : '0;
    enables_hit = addr_valid && (data_addr == TIMER4_ENABLES_ADDR);
  end

  ////////////////////////////////////////////////////////////////////////////
  // flag registers, one per timer

  logic [7:0] flags_reg [NUM_TIMERS];
  logic [7:0] set_vec   [NUM_TIMERS];
  logic [7:0] clr_vec   [NUM_TIMERS];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_timer
      logic       pend_a_reg;
      logic       pend_a_next;
      logic       pend_b_reg;
      logic       pend_b_next;
      logic       top_mode;
      logic [7:0] flags_next;

      // next values of the compare pending bits and the flags
      always_comb begin
        top_mode = capture_is_top(timer_status[gi].waveform_mode_field);
        // compare-a delay
        // a match seen at one tick is held until the next tick sets the flag
        pend_a_next = timer_status[gi].tick ?
                      (timer_status[gi].counter_value == timer_status[gi].compare_a_register) :
                      pend_a_reg;
        pend_b_next = timer_status[gi].tick ?
                      (timer_status[gi].counter_value == timer_status[gi].compare_b_register) :
                      pend_b_reg;
        set_vec[gi] = FLAGS_RESET;
        // force ignored
        // the forced strobes act on the waveform only and never reach set_vec
        set_vec[gi][COMPARE_A_BIT] = timer_status[gi].tick && pend_a_reg;
        set_vec[gi][COMPARE_B_BIT] = timer_status[gi].tick && pend_b_reg;
        set_vec[gi][CAPTURE_BIT] = top_mode ? timer_status[gi].counter_at_top :
                                              timer_status[gi].capture_event;
        if ((timer_status[gi].waveform_mode_field == MODE_NORMAL) ||
            (timer_status[gi].waveform_mode_field == MODE_CTC_COMPARE)) begin
          set_vec[gi][OVERFLOW_BIT] = timer_status[gi].overflow_event;
        end else begin
          set_vec[gi][OVERFLOW_BIT] = timer_status[gi].mode_overflow_event;
        end
        clr_vec[gi] = FLAGS_RESET;
        if (core_access.wr && hit[gi]) begin
          clr_vec[gi] = core_access.wdata & FLAG_MASK;
        end
        clr_vec[gi][CAPTURE_BIT]   = clr_vec[gi][CAPTURE_BIT]   | vector_ack[gi].capture;
        clr_vec[gi][COMPARE_B_BIT] = clr_vec[gi][COMPARE_B_BIT] | vector_ack[gi].compare_b;
        clr_vec[gi][COMPARE_A_BIT] = clr_vec[gi][COMPARE_A_BIT] | vector_ack[gi].compare_a;
        clr_vec[gi][OVERFLOW_BIT]  = clr_vec[gi][OVERFLOW_BIT]  | vector_ack[gi].overflow;
        flags_next = ((flags_reg[gi] & ~clr_vec[gi]) | set_vec[gi]) & FLAG_MASK;
      end

      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          flags_reg[gi] <= FLAGS_RESET;
          pend_a_reg    <= 1'b0;
          pend_b_reg    <= 1'b0;
        end else begin
          flags_reg[gi] <= flags_next;
          pend_a_reg    <= pend_a_next;
          pend_b_reg    <= pend_b_next;
        end
      end

      assign event_flags[gi] = flags_reg[gi];

      a_capture_sets: assert property (
        timer_status[gi].capture_event && !top_mode |=> flags_reg[gi][CAPTURE_BIT])
        else $error("capture event did not set capture flag");
      a_top_capture: assert property (
        top_mode && timer_status[gi].counter_at_top |=> flags_reg[gi][CAPTURE_BIT])
        else $error("top in capture mode did not set capture flag");
      a_ack_clears_cap: assert property (
        vector_ack[gi].capture && !set_vec[gi][CAPTURE_BIT]
        |=> !flags_reg[gi][CAPTURE_BIT])
        else $error("capture vector did not clear capture flag");
      a_cmpb_next_tick: assert property (
        timer_status[gi].tick &&
        timer_status[gi].counter_value == timer_status[gi].compare_b_register
        ##1 (!timer_status[gi].tick && !vector_ack[gi].compare_b && !core_access.wr)[*1]
        ##1 timer_status[gi].tick |=> flags_reg[gi][COMPARE_B_BIT])
        else $error("compare-b flag not set at following tick");
      a_cmpa_not_early: assert property (
        timer_status[gi].tick && !pend_a_reg && !flags_reg[gi][COMPARE_A_BIT]
        |=> !flags_reg[gi][COMPARE_A_BIT])
        else $error("compare-a flag set in the match tick");
      a_force_no_flag: assert property (
        timer_status[gi].force_compare_a_strobe && !pend_a_reg &&
        !flags_reg[gi][COMPARE_A_BIT] |=> !flags_reg[gi][COMPARE_A_BIT])
        else $error("forced strobe set compare-a flag");
      a_w1c_compare: assert property (
        core_access.wr && hit[gi] && core_access.wdata[COMPARE_A_BIT] &&
        !set_vec[gi][COMPARE_A_BIT] |=> !flags_reg[gi][COMPARE_A_BIT])
        else $error("write one did not clear compare-a flag");
      a_normal_overflow: assert property (
        timer_status[gi].waveform_mode_field == MODE_NORMAL &&
        timer_status[gi].overflow_event |=> flags_reg[gi][OVERFLOW_BIT])
        else $error("overflow in normal mode did not set flag");
      a_ack_clears_ovf: assert property (
        vector_ack[gi].overflow && !set_vec[gi][OVERFLOW_BIT]
        |=> !flags_reg[gi][OVERFLOW_BIT])
        else $error("overflow vector did not clear flag");
      a_zero_write_keeps: assert property (
        core_access.wr && hit[gi] && !core_access.wdata[OVERFLOW_BIT] &&
        !vector_ack[gi].overflow && flags_reg[gi][OVERFLOW_BIT]
        |=> flags_reg[gi][OVERFLOW_BIT])
        else $error("zero write changed overflow flag");
      c_compare_flag: cover property (pend_b_reg && timer_status[gi].tick ##1
                                      flags_reg[gi][COMPARE_B_BIT]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // timer 4 enables, read data and requests

  logic [7:0] enables_reg;
  logic [7:0] enables_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       cmpa_irq_reg;
  logic       cmpa_irq_next;
  logic       ovf_irq_reg;
  logic       ovf_irq_next;

  // register writes, reads and request gating
  always_comb begin
    enables_next = enables_reg;
    if (core_access.wr && enables_hit) begin
      enables_next = core_access.wdata & ENABLE_MASK;
    end
    // unmapped reads return zero so software sees no stale bus value
    rdata_next = READ_IDLE;
    if (core_access.rd) begin
      for (int k = 0; k < NUM_TIMERS; k++) begin
        if (hit[k]) begin
          rdata_next = flags_reg[k];
        end
      end
      if (enables_hit) begin
        rdata_next = enables_reg;
      end
    end
    cmpa_irq_next = enables_reg[COMPARE_A_BIT] && global_irq_enable &&
                    flags_reg[T4_INDEX][COMPARE_A_BIT];
    ovf_irq_next  = enables_reg[OVERFLOW_BIT] && global_irq_enable &&
                    flags_reg[T4_INDEX][OVERFLOW_BIT];
  end

  // registered so that every output comes from a flop, at one cycle of latency
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      enables_reg  <= ENABLES_RESET;
      rdata_reg    <= READ_IDLE;
      cmpa_irq_reg <= 1'b0;
      ovf_irq_reg  <= 1'b0;
    end else begin
      enables_reg  <= enables_next;
      rdata_reg    <= rdata_next;
      cmpa_irq_reg <= cmpa_irq_next;
      ovf_irq_reg  <= ovf_irq_next;
    end
  end

  assign core_rdata       = rdata_reg;
  assign t4_compare_a_irq = cmpa_irq_reg;
  assign t4_overflow_irq  = ovf_irq_reg;

  a_cmpa_irq_gate: assert property (@(posedge mclk) disable iff (!reset_n)
    t4_compare_a_irq == $past(enables_reg[COMPARE_A_BIT] && global_irq_enable &&
                              flags_reg[T4_INDEX][COMPARE_A_BIT]))
    else $error("compare-a request not gated correctly");
  a_ovf_irq_gate: assert property (@(posedge mclk) disable iff (!reset_n)
    !global_irq_enable |=> !t4_overflow_irq)
    else $error("overflow request raised with global flag clear");
  a_io_read_map: assert property (@(posedge mclk) disable iff (!reset_n)
    core_access.rd && core_access.io_space &&
    core_access.addr == TIMER4_FLAGS_ADDR - IO_SPACE_OFFSET
    |=> core_rdata == $past(flags_reg[T4_INDEX]))
    else $error("i/o read of timer 4 flags wrong");
  a_unmapped_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    core_access.rd && hit == '0 && !enables_hit |=> core_rdata == READ_IDLE)
    else $error("unmapped read not zero");
  c_irq_raised: cover property (@(posedge mclk) disable iff (!reset_n)
    $rose(t4_compare_a_irq));
  c_io_write: cover property (@(posedge mclk) disable iff (!reset_n)
    core_access.wr && core_access.io_space && hit != '0);
  c_ovf_irq: cover property (@(posedge mclk) disable iff (!reset_n)
    $rose(t4_overflow_irq));

endmodule

// *** core_partner.sv ***
`timescale 1ns/1ps
// behavioural processor core: register loads and stores, vector execution
module core_partner
  import timer16_irq_pkg::*;
(
  // clock
  input  wire logic       mclk,
  // register access
  output core_access_s    core_access,
  input  wire logic [7:0] core_rdata,
  // vector side
  input  wire logic       t4_compare_a_irq,
  input  wire logic       auto_ack,
  output vector_ack_s     vector_ack [NUM_TIMERS]
);
  // idle bus and no vector pending at time zero
  initial begin
    core_access = '0;
    for (int i = 0; i < NUM_TIMERS; i++) vector_ack[i] = '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // software clear
  // one access held over exactly one taking edge; the extra idle cycle keeps
  // back-to-back calls from driving the strobe twice in one time step
  task automatic access(input logic wr, input logic io, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    core_access = '{rd: !wr, wr: wr, io_space: io, addr: a, wdata: d};
    @(negedge mclk);
    q = core_rdata;
    core_access = '0;
    @(negedge mclk);
  endtask

  task automatic vack(input int i, input vector_ack_s a);
    vector_ack[i] = a;
    @(negedge mclk);
    vector_ack[i] = '0;
    @(negedge mclk);
  endtask

  // vector clears flag
  // core takes the compare vector as soon as it is requested, one pulse each
  always @(negedge mclk)
    if (auto_ack)
      vector_ack[T4_INDEX].compare_a = t4_compare_a_irq && !vector_ack[T4_INDEX].compare_a;
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch at %0t: got %h exp %h", $time, (a), (b)); end end
module testbench
  import timer16_irq_pkg::*;
;
  logic          mclk              = 1'b0;
  logic          reset_n           = 1'b0;
  logic          global_irq_enable = 1'b0;
  logic          auto_ack          = 1'b0;
  timer_status_s timer_status [NUM_TIMERS];
  vector_ack_s   vector_ack   [NUM_TIMERS];
  core_access_s  core_access;
  logic [7:0]    core_rdata;
  logic [7:0]    event_flags  [NUM_TIMERS];
  logic          t4_compare_a_irq;
  logic          t4_overflow_irq;
  logic [7:0]    exp_flags    [NUM_TIMERS];
  logic [7:0]    q;
  int            err_count = 0;
  int            n_tests   = 0;
  // overflow cases: mode, which event fires, whether the flag must set
  logic [3:0]    om [5] = '{MODE_NORMAL, MODE_CTC_COMPARE, 4'h1, 4'h1, MODE_NORMAL};
  logic          osel [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  logic          oexp [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
  logic [3:0]    tops [4] = '{MODE_PFC_CAPTURE, MODE_PC_CAPTURE, MODE_CTC_CAPTURE,
                              MODE_FAST_CAPTURE};

  // free-running system clock
  always #5 mclk = ~mclk;

  timer16_irq_flag_logic uut (.mclk(mclk), .reset_n(reset_n), .core_access(core_access),
    .core_rdata(core_rdata), .global_irq_enable(global_irq_enable),
    .timer_status(timer_status), .vector_ack(vector_ack), .event_flags(event_flags),
    .t4_compare_a_irq(t4_compare_a_irq), .t4_overflow_irq(t4_overflow_irq));
  core_partner core (.mclk(mclk), .core_access(core_access), .core_rdata(core_rdata),
    .t4_compare_a_irq(t4_compare_a_irq), .auto_ack(auto_ack), .vector_ack(vector_ack));

  ////////////////////////////////////////////////////////////////////////////////
  // expected address of a flag register in either space
  function automatic logic [7:0] flag_addr(input int i, input logic io);
    logic [7:0] a;
    a = (i == 0) ? TIMER1_FLAGS_ADDR : (i == 1) ? TIMER3_FLAGS_ADDR : TIMER4_FLAGS_ADDR;
    return io ? a - IO_SPACE_OFFSET : a;
  endfunction

  // flag bits that a vector acknowledge clears
  function automatic logic [7:0] ack_mask(input vector_ack_s a);
    return {2'b00, a.capture, 2'b00, a.compare_b, a.compare_a, a.overflow};
  endfunction

  task automatic complete_run();
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // one cycle of timer status, then an idle cycle so the flag has landed
  task automatic ev(input int i, input timer_status_s s);
    timer_status[i] = s;
    @(negedge mclk);
    timer_status[i] = '0;
    @(negedge mclk);
  endtask

  task automatic wflag(input int i, input logic io, input logic [7:0] d);
    core.access(1'b1, io, flag_addr(i, io), d, q);
    exp_flags[i] &= ~d;
  endtask

  // all four events at once; second tick completes the compare matches
  task automatic set_all(input int i);
    timer_status_s s;
    s = '0;
    s.tick = 1'b1;
    s.capture_event = 1'b1;
    s.overflow_event = 1'b1;
    ev(i, s);
    s.counter_value = 16'h0001;
    ev(i, s);
    exp_flags[i] = FLAG_MASK;
  endtask

  // flag outputs and readback, timer 3 through the i/o space
  task automatic chk_all();
    for (int i = 0; i < NUM_TIMERS; i++) begin
      `CHK(event_flags[i], exp_flags[i])
      core.access(1'b0, i[0], flag_addr(i, i[0]), 8'h00, q);
      `CHK(q, exp_flags[i])
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // a hung wait ends the run here
  initial begin
    repeat (50000) @(posedge mclk);
    err_count++;
    complete_run();
  end

  // main sequence
  initial begin
    timer_status_s s;
    logic [15:0]   c;
    logic [7:0]    d;
    vector_ack_s   a;
    for (int i = 0; i < NUM_TIMERS; i++) timer_status[i] = '0;
    for (int i = 0; i < NUM_TIMERS; i++) exp_flags[i] = FLAGS_RESET;
    q = 8'($urandom(32'he5a6));
    repeat (8) @(negedge mclk);
    reset_n = 1'b1;
    @(negedge mclk);
    chk_all();
    // i/o alias of the enables lies above 0x3f, so this write must be lost
    core.access(1'b1, 1'b1, 8'h52, 8'hff, q);
    core.access(1'b0, 1'b0, TIMER4_ENABLES_ADDR, 8'h00, q);
    `CHK(q, ENABLES_RESET)
    core.access(1'b0, 1'b0, 8'h37, 8'h00, q);
    `CHK(q, READ_IDLE)
    for (int i = 0; i < NUM_TIMERS; i++) begin
      s = '0;
      s.capture_event = 1'b1;
      ev(i, s);
      exp_flags[i][CAPTURE_BIT] = 1'b1;
      chk_all();
      wflag(i, 1'b1, 8'h00);
      chk_all();
      wflag(i, 1'b1, 8'h20);
      chk_all();
      // capture-top modes ignore the pin and flag on reaching top instead
      foreach (tops[k]) begin
        s = '0;
        s.waveform_mode_field = tops[k];
        s.capture_event = 1'b1;
        ev(i, s);
        chk_all();
        s.capture_event = 1'b0;
        s.counter_at_top = 1'b1;
        ev(i, s);
        exp_flags[i][CAPTURE_BIT] = 1'b1;
        chk_all();
        wflag(i, 1'b0, 8'h20);
      end
      c = 16'($urandom);
      s = '0;
      s.tick = 1'b1;
      s.force_compare_a_strobe = 1'b1;
      s.force_compare_b_strobe = 1'b1;
      s.compare_a_register = c;
      s.compare_b_register = c ^ 16'h0001;
      s.counter_value = c + 16'h0002;
      ev(i, s);
      ev(i, s);
      chk_all();
      s.counter_value = c;
      ev(i, s);
      chk_all();
      s.counter_value = c + 16'h0002;
      ev(i, s);
      exp_flags[i][COMPARE_A_BIT] = 1'b1;
      chk_all();
      s.counter_value = c ^ 16'h0001;
      ev(i, s);
      s.counter_value = c + 16'h0002;
      ev(i, s);
      exp_flags[i][COMPARE_B_BIT] = 1'b1;
      chk_all();
      for (int k = 0; k < 5; k++) begin
        s = '0;
        s.waveform_mode_field = om[k];
        s.overflow_event = !osel[k];
        s.mode_overflow_event = osel[k];
        ev(i, s);
        exp_flags[i][OVERFLOW_BIT] = exp_flags[i][OVERFLOW_BIT] | oexp[k];
        chk_all();
        wflag(i, 1'b1, 8'h01);
      end
      chk_all();
      set_all(i);
      a = 4'($urandom);
      core.vack(i, a);
      exp_flags[i] &= ~ack_mask(a);
      chk_all();
      set_all(i);
      // a clear of every flag in the very cycle that capture and overflow set
      s = '0;
      s.capture_event = 1'b1;
      s.overflow_event = 1'b1;
      timer_status[i] = s;
      fork
        core.access(1'b1, 1'b0, flag_addr(i, 1'b0), 8'h27, q);
        begin
          @(negedge mclk);
          timer_status[i] = '0;
        end
      join
      exp_flags[i] = 8'h21;
      chk_all();
      wflag(i, 1'b0, 8'($urandom));
      chk_all();
    end
    set_all(T4_INDEX);
    for (int k = 0; k < 16; k++) begin
      if (k == 8)
        wflag(T4_INDEX, 1'b0, 8'hff);
      d = 8'($urandom);
      d[1:0] = k[1:0];
      global_irq_enable = k[2];
      core.access(1'b1, 1'b0, TIMER4_ENABLES_ADDR, d, q);
      core.access(1'b0, 1'b0, TIMER4_ENABLES_ADDR, 8'h00, q);
      `CHK(q, d & ENABLE_MASK)
      `CHK(t4_compare_a_irq, k[1] & k[2] & exp_flags[T4_INDEX][1])
      `CHK(t4_overflow_irq, k[0] & k[2] & exp_flags[T4_INDEX][0])
    end
    // requested vector executes and takes the compare flag with it
    set_all(T4_INDEX);
    core.access(1'b1, 1'b0, TIMER4_ENABLES_ADDR, 8'h02, q);
    global_irq_enable = 1'b1;
    auto_ack = 1'b1;
    for (int n = 0; n < 20 && event_flags[T4_INDEX][1] !== 1'b0; n++) @(negedge mclk);
    `CHK(event_flags[T4_INDEX][1], 1'b0)
    @(negedge mclk);
    auto_ack = 1'b0;
    exp_flags[T4_INDEX][COMPARE_A_BIT] = 1'b0;
    chk_all();
    complete_run();
  end
endmodule
